// ---- verif/dfq_diode_model.sv ----
// Remote diode wiring model and pull-ups on the two open-drain lines.
// Fault kind 0 is a healthy diode; 1..6 pick one wiring defect.
`timescale 1ns/1ps
`default_nettype none
module dfq_diode_model (
    input wire logic [2:0] faultKind,
    input wire logic alertPinOut,
    input wire logic alertPinOe,
    input wire logic thermPinOut,
    input wire logic thermPinOe,
    output var dfq_pkg::dfq_diode_state_type diodeState,
    output var logic alertLine,
    output var logic thermLine
);
    import dfq_pkg::*;
    // One defect at a time, walking the struct fields from the top
    assign diodeState = (faultKind == 3'h0) ? '0 :
        dfq_diode_state_type'(6'h20 >> (faultKind - 3'h1));
    // Released lines go to the pull-up level, never hold old values
    assign alertLine = alertPinOe ? alertPinOut : 1'b1;
    assign thermLine = thermPinOe ? thermPinOut : 1'b1;
endmodule
`default_nettype wire

// ---- verif/dfq_qualifier_properties.sv ----
// Port-level checker for the event qualifier.
// Bound to every dfq_qualifier; one clock, async active-low reset.
`timescale 1ns/1ps
`default_nettype none
module dfq_qualifier_properties (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic measDone,
    input wire logic [1:0] measChannel,
    input wire dfq_pkg::dfq_channel_type measInfo,
    input wire dfq_pkg::dfq_diode_state_type diodeState,
    input wire logic comparatorMode,
    input wire logic [7:0] hysteresis,
    input wire logic statusClear,
    input wire logic [7:0] resultHigh,
    input wire logic [7:0] resultLow,
    input wire logic resultValid,
    input wire logic [3:0] highStatus,
    input wire logic [3:0] lowStatus,
    input wire logic [3:0] faultStatus,
    input wire logic alertPinOut,
    input wire logic alertPinOe,
    input wire logic thermPinOut,
    input wire logic thermPinOe
);
    import dfq_pkg::*;
    wire logic take = measDone && measInfo.enabled;
    wire logic ext = measChannel != 2'h0;
    wire logic flt = diodeState.anodeOpen || diodeState.supplyToAnode
        || diodeState.supplyToCathode;
    wire logic ashort = diodeState.anodeToCathode || diodeState.anodeToGround;
    wire logic thermHit = take && measInfo.temp > measInfo.thermLimit;
    // A fault or anode short reads as zero, which also lets the pin go
    wire logic thermDrop = take && (ext && (flt || ashort)
        || measInfo.temp < measInfo.thermLimit - hysteresis);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_valid_take: assert property (take |=> resultValid)
        else $error("no result after a measurement");
    a_skip_disabled: assert property (measDone && !measInfo.enabled
        && !statusClear |=> !resultValid && $stable(highStatus))
        else $error("disabled channel was qualified");
    a_fault_zero: assert property (take && ext && flt
        |=> resultHigh == 8'h00 && resultLow == 8'h00)
        else $error("fault result not zero");
    a_fault_no_low: assert property (take && ext && flt
        && !statusClear |=> $stable(lowStatus))
        else $error("low status set on a fault");
    a_short_quiet: assert property (take && ext && ashort && !flt
        && !statusClear |=> resultHigh == 8'h00 && $stable(faultStatus))
        else $error("anode short misreported");
    a_masked_quiet: assert property (take && measInfo.alertMasked
        && !alertPinOe |=> !alertPinOe)
        else $error("masked channel raised alert");
    a_comp_quiet: assert property (comparatorMode && take && !alertPinOe
        && measInfo.temp <= measInfo.highLimit |=> !alertPinOe)
        else $error("comparator alert without high event");
    a_int_holds: assert property (!comparatorMode && alertPinOe
        && !statusClear ##1 !comparatorMode |-> alertPinOe)
        else $error("interrupt alert dropped without clear");
    a_status_cause: assert property
        ((highStatus & ~$past(highStatus)) != 4'h0 |-> $past(take))
        else $error("high status set without measurement");
    a_therm_cause: assert property ($rose(thermPinOe) |-> $past(thermHit))
        else $error("therm pin rose without over-limit");
    a_therm_release: assert property
        ($fell(thermPinOe) |-> $past(thermDrop))
        else $error("therm pin released inside hysteresis");
    a_drain_only: assert property (!alertPinOut && !thermPinOut)
        else $error("open-drain output driven high");

    c_int_alert: cover property (!comparatorMode && $rose(alertPinOe));
    c_comp_alert: cover property (comparatorMode && $rose(alertPinOe));
    c_therm: cover property ($rose(thermPinOe));
    c_fault: cover property (take && ext && flt);
endmodule

bind dfq_qualifier dfq_qualifier_properties chk (.clk, .rst_b, .measDone,
    .measChannel, .measInfo, .diodeState, .comparatorMode, .hysteresis,
    .statusClear, .resultHigh, .resultLow, .resultValid, .highStatus,
    .lowStatus, .faultStatus, .alertPinOut, .alertPinOe, .thermPinOut,
    .thermPinOe);
`default_nettype wire

// ---- verif/tb_dfq_qualifier.sv ----
// Self-checking bench for the qualifier, diode model on the far side.
// Inputs change 2 ns after a rising edge; outputs read after it.
`timescale 1ns/1ps
`default_nettype none
module tb_dfq_qualifier;
    import dfq_pkg::*;
    logic clk, rst_b, measDone, comparatorMode, statusClear, regWrite;
    logic resultValid, alertPinOut, alertPinOe, thermPinOut, thermPinOe;
    logic alertLine, thermLine;
    logic [1:0] measChannel;
    logic [2:0] faultKind, bjtModel;
    logic [7:0] hysteresis, regAddr, regWdata, regRdata;
    logic [7:0] resultHigh, resultLow;
    logic [3:0] highStatus, lowStatus, faultStatus, thermStatus;
    dfq_channel_type measInfo;
    dfq_diode_state_type diodeState;
    int numErrors = 0;
    int samplesChecked = 0;
    int cycles = 0;

    dfq_qualifier uut (.clk, .rst_b, .measDone, .measChannel, .measInfo,
        .diodeState, .comparatorMode, .hysteresis, .bjtModel, .statusClear,
        .regWrite, .regAddr, .regWdata, .regRdata, .resultHigh, .resultLow,
        .resultValid, .highStatus, .lowStatus, .faultStatus, .thermStatus,
        .alertPinOut, .alertPinOe, .thermPinOut, .thermPinOe);
    dfq_diode_model dm (.faultKind, .alertPinOut, .alertPinOe,
        .thermPinOut, .thermPinOe, .diodeState, .alertLine, .thermLine);

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic complete_run;
        $display("mismatches %0d checks %0d", numErrors, samplesChecked);
        if (numErrors == 0 && samplesChecked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Whole run is about a hundred cycles; this cuts a hang short
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            numErrors++;
            complete_run;
        end
    end

    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        samplesChecked++;
        if (g !== e) begin
            numErrors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic st(string n, logic [3:0] e, logic [3:0] g);
        chk(n, {4'h0, e}, {4'h0, g});
    endtask
    task automatic al(logic e);
        chk("alertLine", {7'h0, e}, {7'h0, alertLine});
    endtask
    task automatic tl(logic e);
        chk("thermLine", {7'h0, e}, {7'h0, thermLine});
    endtask
    task automatic step;
        @(posedge clk);
        #2;
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        step;
        regWrite = 1'b1;
        regAddr = a;
        regWdata = d;
        step;
        regWrite = 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] e);
        step;
        regAddr = a;
        #1;
        chk("register", e, regRdata);
    endtask
    task automatic meas(logic [1:0] ch, logic [7:0] t, logic [2:0] k);
        step;
        measDone = 1'b1;
        measChannel = ch;
        measInfo.temp = t;
        faultKind = k;
        step;
        measDone = 1'b0;
    endtask
    task automatic clr;
        step;
        statusClear = 1'b1;
        step;
        statusClear = 1'b0;
    endtask

    initial begin
        rst_b = 1'b0;
        {measDone, comparatorMode, statusClear, regWrite} = 4'h0;
        {measChannel, faultKind, regAddr, regWdata} = '0;
        bjtModel = 3'h5;
        hysteresis = 8'h05;
        measInfo = '{8'h00, 8'h50, 8'h10, 8'h60, 1'b1, 1'b0};
        repeat (6) @(posedge clk);
        #2;
        rst_b = 1'b1;
        rd(8'h22, 8'h70);
        for (int i = 0; i < 3; i++) rd(8'(8'h30 + i), 8'h12);
        // No beta compensation runs here, so ideality may change
        wr(8'h30, 8'h08);
        wr(8'h31, 8'h38);
        wr(8'h32, 8'h37);
        wr(8'h32, 8'h07);
        rd(8'h30, 8'h08);
        rd(8'h31, 8'h12);
        rd(8'h32, 8'h37);
        wr(8'h22, 8'h25);
        rd(8'h22, 8'h70);
        meas(2'd1, 8'h51, 3'd0);
        st("highStatus", 4'h2, highStatus);
        al(1'b0);
        clr;
        al(1'b1);
        for (int k = 1; k < 4; k++) begin
            meas(2'd2, 8'h30, 3'(k));
            chk("resultHigh", 8'h00, resultHigh);
            chk("resultLow", 8'h00, resultLow);
            st("faultStatus", 4'h4, faultStatus);
            st("lowStatus", 4'h0, lowStatus);
            al(1'b0);
            clr;
        end
        measInfo.alertMasked = 1'b1;
        meas(2'd3, 8'h30, 3'd1);
        st("faultStatus", 4'h8, faultStatus);
        al(1'b1);
        measInfo.alertMasked = 1'b0;
        clr;
        for (int k = 4; k < 6; k++) begin
            meas(2'd1, 8'h30, 3'(k));
            chk("resultHigh", 8'h00, resultHigh);
            st("faultStatus", 4'h0, faultStatus);
            st("lowStatus", 4'h0, lowStatus);
            al(1'b1);
        end
        meas(2'd1, 8'h30, 3'd6);
        chk("resultHigh", 8'h30, resultHigh);
        al(1'b1);
        measInfo.enabled = 1'b0;
        meas(2'd1, 8'h51, 3'd0);
        st("highStatus", 4'h0, highStatus);
        measInfo.enabled = 1'b1;
        wr(8'h22, 8'h71);
        rd(8'h22, 8'h71);
        meas(2'd1, 8'h51, 3'd0);
        meas(2'd1, 8'h30, 3'd0);
        meas(2'd1, 8'h51, 3'd0);
        al(1'b1);
        meas(2'd2, 8'h08, 3'd0);
        meas(2'd1, 8'h51, 3'd0);
        st("highStatus", 4'h2, highStatus);
        al(1'b0);
        meas(2'd2, 8'h08, 3'd0);
        st("lowStatus", 4'h4, lowStatus);
        clr;
        meas(2'd1, 8'h51, 3'd0);
        al(1'b1);
        repeat (3) meas(2'd1, 8'h61, 3'd0);
        tl(1'b1);
        meas(2'd1, 8'h61, 3'd0);
        tl(1'b0);
        st("thermStatus", 4'h2, thermStatus);
        meas(2'd1, 8'h5D, 3'd0);
        tl(1'b0);
        meas(2'd1, 8'h50, 3'd0);
        tl(1'b1);
        clr;
        wr(8'h22, 8'h70);
        comparatorMode = 1'b1;
        meas(2'd3, 8'h30, 3'd2);
        st("faultStatus", 4'h8, faultStatus);
        meas(2'd3, 8'h08, 3'd0);
        st("lowStatus", 4'h8, lowStatus);
        al(1'b1);
        meas(2'd1, 8'h51, 3'd0);
        al(1'b0);
        meas(2'd1, 8'h4D, 3'd0);
        al(1'b0);
        meas(2'd1, 8'h40, 3'd0);
        al(1'b1);
        complete_run;
    end
endmodule
`default_nettype wire

// ---- verilog/dfq_defines.svh ----
// Constants for the diode fault and alert qualifier.
// Included by the package and by every design file; definitions only.
`ifndef DFQ_DEFINES_SVH
`define DFQ_DEFINES_SVH

`define DFQ_NUM_CH 4
`define DFQ_NUM_EXT 3
`define DFQ_TEMP_W 8
`define DFQ_ADDR_W 8
`define DFQ_ADDR_CONSEC 8'h22
`define DFQ_ADDR_IDEAL0 8'h30
`define DFQ_CONSEC_RST 8'h70
`define DFQ_ALERT_LO 0
`define DFQ_ALERT_HI 2
`define DFQ_THERM_LO 4
`define DFQ_THERM_HI 6
`define DFQ_IDEAL_W 6
`define DFQ_IDEAL_RST 6'h12
`define DFQ_IDEAL_MIN 6'h08
`define DFQ_IDEAL_MAX 6'h37
`define DFQ_FAULT_RESULT 8'h00
`define DFQ_CNT_W 3
`define DFQ_FACTOR_W 14
`define DFQ_DIODE_REF 14'h2760
`define DFQ_BJT_REF 14'h2710
`define DFQ_BJT_OFFSET 14'h0050

`endif

// ---- verilog/dfq_ideality.sv ----
// Ideality setting store and factor lookup for one external diode.
// Factor is a fixed-point value, 1.0000 equals 10000 counts.
`timescale 1ns/1ps
`default_nettype none
`include "dfq_defines.svh"

module dfq_ideality (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic write_en,
    input wire logic [`DFQ_IDEAL_W-1:0] write_data,
    input wire logic bjt_model,
    output logic [`DFQ_IDEAL_W-1:0] setting,
    output logic [`DFQ_FACTOR_W-1:0] factor
);
    logic codeValid;
    logic signed [`DFQ_FACTOR_W-1:0] step;
    logic [`DFQ_FACTOR_W-1:0] diodeFactor;

    assign codeValid = (write_data >= `DFQ_IDEAL_MIN)
        && (write_data <= `DFQ_IDEAL_MAX);
    // Linear fit of the table: about 13.2 counts per code around 12h
    assign step = `DFQ_FACTOR_W'(($signed({1'b0, setting})
        - $signed({1'b0, `DFQ_IDEAL_RST})) * 132 / 10);
    assign diodeFactor = `DFQ_DIODE_REF + step;
    assign factor = bjt_model ? diodeFactor - `DFQ_BJT_OFFSET
        : diodeFactor;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            setting <= `DFQ_IDEAL_RST;
        end else if (write_en && codeValid) begin
            setting <= write_data;
        end
    end
endmodule
`default_nettype wire

// ---- verilog/dfq_pkg.sv ----
// Types shared by the qualifier and its helpers.
// Relies on dfq_defines.svh for widths.
`include "dfq_defines.svh"

package dfq_pkg;
    typedef struct packed {
        logic [`DFQ_TEMP_W-1:0] temp;
        logic [`DFQ_TEMP_W-1:0] highLimit;
        logic [`DFQ_TEMP_W-1:0] lowLimit;
        logic [`DFQ_TEMP_W-1:0] thermLimit;
        logic enabled;
        logic alertMasked;
    } dfq_channel_type;

    typedef struct packed {
        logic anodeOpen;
        logic supplyToAnode;
        logic supplyToCathode;
        logic anodeToCathode;
        logic anodeToGround;
        logic cathodeToGround;
    } dfq_diode_state_type;

    typedef enum logic [1:0] {
        DFQ_IDLE = 2'b00,
        DFQ_EVAL = 2'b01,
        DFQ_DONE = 2'b10
    } dfq_state_type;
endpackage

// ---- verilog/dfq_qualifier.sv ----
// Event qualifier: diode faults, consecutive counters, alert and
// overtemperature pins. Channel 0 is internal, 1..3 external diodes.
// Assumes the register port is on this clock and pins are synchronised.
`timescale 1ns/1ps
`default_nettype none
`include "dfq_defines.svh"

module dfq_qualifier (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic measDone,
    input wire logic [1:0] measChannel,
    input wire dfq_pkg::dfq_channel_type measInfo,
    input wire dfq_pkg::dfq_diode_state_type diodeState,
    input wire logic comparatorMode,
    input wire logic [`DFQ_TEMP_W-1:0] hysteresis,
    input wire logic [`DFQ_NUM_EXT-1:0] bjtModel,
    input wire logic statusClear,
    input wire logic regWrite,
    input wire logic [`DFQ_ADDR_W-1:0] regAddr,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    output logic [`DFQ_TEMP_W-1:0] resultHigh,
    output logic [`DFQ_TEMP_W-1:0] resultLow,
    output logic resultValid,
    output logic [`DFQ_NUM_CH-1:0] highStatus,
    output logic [`DFQ_NUM_CH-1:0] lowStatus,
    output logic [`DFQ_NUM_CH-1:0] faultStatus,
    output logic [`DFQ_NUM_CH-1:0] thermStatus,
    output logic alertPinOut,
    output logic alertPinOe,
    output logic thermPinOut,
    output logic thermPinOe
);
    import dfq_pkg::*;

    logic [7:0] consecCount;
    logic [`DFQ_NUM_CH-1:0] alertFire;
    logic [`DFQ_NUM_CH-1:0] thermFire;
    logic [`DFQ_NUM_CH-1:0] thermHeld;
    logic [`DFQ_NUM_CH-1:0] alertHeld;
    logic [`DFQ_NUM_CH-1:0] chanSel;
    logic [`DFQ_IDEAL_W-1:0] idealSetting [`DFQ_NUM_EXT];
    logic [`DFQ_NUM_CH-1:0] next_highStatus;
    logic [`DFQ_NUM_CH-1:0] next_lowStatus;
    logic [`DFQ_NUM_CH-1:0] next_faultStatus;
    logic [`DFQ_NUM_CH-1:0] next_thermStatus;
    logic [`DFQ_NUM_CH-1:0] maskVec;
    logic [`DFQ_NUM_CH-1:0] alertReq;
    logic alertCompare;
    logic [`DFQ_NUM_CH-1:0] chanMask;
    logic [`DFQ_NUM_CH-1:0] alertLetGo;
    logic [`DFQ_NUM_CH-1:0] thermLetGo;

    wire isExternal = (measChannel != 2'd0);
    // Only opens and supply shorts count as faults
    wire diodeFault = isExternal && (diodeState.anodeOpen
        || diodeState.supplyToAnode || diodeState.supplyToCathode);
    // Shorts that collapse the junction read as zero, not as a fault
    wire shortToZero = isExternal && !diodeFault
        && (diodeState.anodeToCathode || diodeState.anodeToGround);
    // Cathode-to-ground short changes nothing here
    wire forcedZero = diodeFault || shortToZero;
    wire [`DFQ_TEMP_W-1:0] effTemp = forcedZero ? `DFQ_FAULT_RESULT
        : measInfo.temp;
    wire measureOn = measDone && measInfo.enabled;
    wire isHigh = effTemp > measInfo.highLimit;
    wire isLow = !forcedZero && (effTemp < measInfo.lowLimit);
    wire isTherm = effTemp > measInfo.thermLimit;
    wire [8:0] highRelease = {1'b0, measInfo.highLimit} - {1'b0, hysteresis};
    wire [8:0] thermRelease = {1'b0, measInfo.thermLimit}
        - {1'b0, hysteresis};
    wire highClear = highRelease[8] ? 1'b0
        : ({1'b0, effTemp} < highRelease);
    wire thermClear = thermRelease[8] ? 1'b0
        : ({1'b0, effTemp} < thermRelease);
    // Comparator mode counts only high-limit exceedances
    wire alertEvent = comparatorMode ? isHigh
        : (isHigh || isLow || diodeFault);
    wire [2:0] alertField = regWdata[`DFQ_ALERT_HI:`DFQ_ALERT_LO];
    wire [2:0] thermField = regWdata[`DFQ_THERM_HI:`DFQ_THERM_LO];
    wire alertFieldOk = (alertField == 3'b000) || (alertField == 3'b001)
        || (alertField == 3'b011) || (alertField == 3'b111);
    wire thermFieldOk = (thermField == 3'b000) || (thermField == 3'b001)
        || (thermField == 3'b011) || (thermField == 3'b111);
    wire consecWrite = regWrite && (regAddr == `DFQ_ADDR_CONSEC);
    wire anyHighRead = (regAddr == `DFQ_ADDR_CONSEC);
    wire [`DFQ_ADDR_W-1:0] idealIndex = regAddr - `DFQ_ADDR_IDEAL0;
    wire idealHit = (regAddr >= `DFQ_ADDR_IDEAL0)
        && (idealIndex < `DFQ_ADDR_W'(`DFQ_NUM_EXT));

    genvar gi;
    generate
        for (gi = 0; gi < `DFQ_NUM_CH; gi = gi + 1) begin : gChan
            assign chanSel[gi] = measureOn && (measChannel == 2'(gi));
            dfq_repeat_counter uAlert (
                .clk(clk),
                .rst_b(rst_b),
                .measure(chanSel[gi]),
                .event_hit(alertEvent),
                .hold_release(highClear),
                .hold_mode(comparatorMode),
                .repeat_count(consecCount[`DFQ_ALERT_HI:`DFQ_ALERT_LO]),
                .fire(alertFire[gi]),
                .holding(alertHeld[gi])
            );
            dfq_repeat_counter uTherm (
                .clk(clk),
                .rst_b(rst_b),
                .measure(chanSel[gi]),
                .event_hit(isTherm),
                .hold_release(thermClear),
                .hold_mode(1'b1),
                .repeat_count(consecCount[`DFQ_THERM_HI:`DFQ_THERM_LO]),
                .fire(thermFire[gi]),
                .holding(thermHeld[gi])
            );
            if (gi > 0) begin : gIdeal
                dfq_ideality uIdeal (
                    .clk(clk),
                    .rst_b(rst_b),
                    .write_en(regWrite && idealHit
                        && (idealIndex == `DFQ_ADDR_W'(gi - 1))),
                    .write_data(regWdata[`DFQ_IDEAL_W-1:0]),
                    .bjt_model(bjtModel[gi - 1]),
                    .setting(idealSetting[gi - 1]),
                    .factor()
                );
            end
            assign maskVec[gi] = (measChannel == 2'(gi))
                && measInfo.alertMasked;
            // A held counter lets go on the edge that takes this measurement
            assign alertLetGo[gi] = chanSel[gi] && alertHeld[gi]
                && highClear;
            assign thermLetGo[gi] = chanSel[gi] && thermHeld[gi]
                && thermClear;
        end
    endgenerate

    // Status bits are set by the qualified event, low and fault by any comparator-mode reading; set wins over clear
    always_comb begin
        next_highStatus = statusClear ? '0 : highStatus;
        next_lowStatus = statusClear ? '0 : lowStatus;
        next_faultStatus = statusClear ? '0 : faultStatus;
        next_thermStatus = statusClear ? '0 : thermStatus;
        for (int i = 0; i < `DFQ_NUM_CH; i++) begin
            if (alertFire[i]) begin
                next_highStatus[i] = next_highStatus[i] | isHigh;
                next_lowStatus[i] = next_lowStatus[i]
                    | (isLow && !comparatorMode);
                next_faultStatus[i] = next_faultStatus[i]
                    | (diodeFault && !comparatorMode);
            end
            if (chanSel[i] && comparatorMode) begin
                next_lowStatus[i] = next_lowStatus[i] | isLow;
                next_faultStatus[i] = next_faultStatus[i] | diodeFault;
            end
            if (thermFire[i]) begin
                next_thermStatus[i] = 1'b1;
            end
        end
    end

    // Status then mask then pin
    assign alertReq = alertFire & ~maskVec;
    // Comparator alert follows held counters of unmasked channels; a
    // counter letting go drops the pin on the edge that takes the reading
    assign alertCompare = |(alertHeld & ~chanMask & ~alertLetGo)
        || (|alertReq);
    // Mask is kept per channel so that a held comparator alert obeys it
    wire [`DFQ_NUM_CH-1:0] next_chanMask = (chanSel & maskVec)
        | (~chanSel & chanMask);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            chanMask <= '0;
        end else begin
            chanMask <= next_chanMask;
        end
    end

    always_comb begin
        regRdata = 8'h00;
        if (anyHighRead) begin
            regRdata = consecCount;
        end else if (idealHit) begin
            regRdata = {2'b00, idealSetting[idealIndex[1:0]]};
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            consecCount <= `DFQ_CONSEC_RST;
        end else if (consecWrite && alertFieldOk && thermFieldOk) begin
            consecCount <= regWdata;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            highStatus <= '0;
            lowStatus <= '0;
            faultStatus <= '0;
            thermStatus <= '0;
        end else begin
            highStatus <= next_highStatus;
            lowStatus <= next_lowStatus;
            faultStatus <= next_faultStatus;
            thermStatus <= next_thermStatus;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            resultHigh <= '0;
            resultLow <= '0;
            resultValid <= 1'b0;
        end else begin
            resultValid <= measureOn;
            if (measureOn) begin
                resultHigh <= effTemp;
                resultLow <= forcedZero ? `DFQ_FAULT_RESULT : 8'h00;
            end
        end
    end

    // Open-drain pins: enable high pulls the pin low
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            alertPinOe <= 1'b0;
            thermPinOe <= 1'b0;
            alertPinOut <= 1'b0;
            thermPinOut <= 1'b0;
        end else begin
            if (comparatorMode) begin
                alertPinOe <= alertCompare;
            end else if (|alertReq) begin
                alertPinOe <= 1'b1;
            end else if (statusClear) begin
                alertPinOe <= 1'b0;
            end
            thermPinOe <= |((thermHeld & ~thermLetGo) | thermFire);
        end
    end
endmodule
`default_nettype wire

// ---- verilog/dfq_repeat_counter.sv ----
// One consecutive-event counter with a thermometer-coded threshold.
// Updated only when the parent pulses measure for its channel.
`timescale 1ns/1ps
`default_nettype none
`include "dfq_defines.svh"

module dfq_repeat_counter (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic measure,
    input wire logic event_hit,
    input wire logic hold_release,
    input wire logic hold_mode,
    input wire logic [`DFQ_CNT_W-1:0] repeat_count,
    output logic fire,
    output logic holding
);
    logic [`DFQ_CNT_W-1:0] count;
    logic [`DFQ_CNT_W-1:0] target;
    logic reach;
    logic [`DFQ_CNT_W-1:0] next_count;
    logic next_holding;

    // Thermometer code: zeros mean 1, each set bit adds one
    assign target = `DFQ_CNT_W'(repeat_count[0]) + `DFQ_CNT_W'(repeat_count[1])
        + `DFQ_CNT_W'(repeat_count[2]) + `DFQ_CNT_W'(1);
    assign reach = event_hit && (count + `DFQ_CNT_W'(1) >= target);
    assign fire = measure && reach && !holding;

    always_comb begin
        next_count = count;
        next_holding = holding;
        if (measure) begin
            if (holding) begin
                // Held until below the limit minus hysteresis
                if (hold_release) begin
                    next_count = '0;
                    next_holding = 1'b0;
                end
            end else if (!event_hit) begin
                next_count = '0;
            end else if (reach) begin
                next_count = hold_mode ? target : '0;
                next_holding = hold_mode;
            end else begin
                next_count = count + `DFQ_CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count <= '0;
            holding <= 1'b0;
        end else begin
            count <= next_count;
            holding <= next_holding;
        end
    end
endmodule
`default_nettype wire
